// ### bitplane_playfield_control.sv
// Playfield control registers and hold-and-modify colour path behind AXI4-Lite.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
module bitplane_playfield_control (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic awvalid,
  output logic awready,
  input wire logic [playfield_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read.
  input wire logic arvalid,
  output logic arready,
  input wire logic [playfield_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Pixel input from the plane fetch.
  input wire logic pixel_valid,
  input wire logic line_start,
  input wire logic [5:0] plane_bits,
  // Pixel output and video controls.
  output logic pixel_out_valid,
  output logic [11:0] pixel_color,
  output logic hold_modify_active,
  output logic external_sync_enable,
  output logic interlace_enable,
  output logic light_pen_enable,
  output logic genlock_audio_enable,
  output logic color_burst_enable,
  output logic dual_playfield_enable,
  output logic high_resolution_select,
  output logic [2:0] active_plane_count,
  output logic [3:0] first_playfield_delay,
  output logic [3:0] second_playfield_delay,
  output logic second_playfield_priority,
  output logic [5:0] sprite_priority,
  output logic [4:0] fetch_start_h,
  output logic [4:0] fetch_stop_h,
  output logic [7:0] window_vertical_begin,
  output logic [7:0] window_horizontal_begin,
  output logic [7:0] window_vertical_end,
  output logic [7:0] window_horizontal_end,
  output logic [15:0] odd_plane_modulo,
  output logic [15:0] even_plane_modulo
);
  import playfield_pkg::*;

  logic [15:0] plane_main_control;
  logic [15:0] plane_scroll_delay;
  logic [15:0] plane_priority_control;
  logic [15:0] fetch_start_position;
  logic [15:0] fetch_stop_position;
  logic [15:0] window_start_coords;
  logic [15:0] window_stop_coords;
  logic [15:0] plane_pointer_high [NUM_PLANES];
  logic [15:0] plane_pointer_low [NUM_PLANES];
  logic [11:0] palette [NUM_PAL];
  logic [11:0] held_color;
  logic have_aw;
  logic have_w;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic wr_hit;
  logic hold_on;
  logic [1:0] mode_bits;
  logic [3:0] low_bits;
  logic [11:0] left_color;
  logic [11:0] next_color;
  logic [31:0] next_rdata;
  logic rd_hit;
  logic [2:0] wr_plane;
  logic [2:0] rd_plane;

  // Write address and data are captured independently, in either order.
  // Each ready is registered as the value it would have after this edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw <= 1'b0;
      awready <= 1'b0;
      wr_addr <= '0;
    end else if (do_write) begin
      have_aw <= 1'b0;
      awready <= 1'b0;
    end else if (awvalid && awready) begin
      have_aw <= 1'b1;
      awready <= 1'b0;
      wr_addr <= awaddr;
    end else begin
      awready <= !have_aw && !(bvalid && !bready);
    end
  end

  // Write data side.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_w <= 1'b0;
      wready <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (do_write) begin
      have_w <= 1'b0;
      wready <= 1'b0;
    end else if (wvalid && wready) begin
      have_w <= 1'b1;
      wready <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else begin
      wready <= !have_w && !(bvalid && !bready);
    end
  end

  // A write completes once both halves are held and the last response is gone.
  assign do_write = have_aw && have_w && !bvalid;

  // Writes lacking either of the two low byte strobes are refused, for every register; upper strobes are ignored.
  always_comb begin
    wr_hit = 1'b0;
    if (wr_strb[1:0] == 2'h3) begin
      if (wr_addr <= OFF_STATUS - 8'h04 && wr_addr[1:0] == 2'h0) begin
        wr_hit = 1'b1;
      end
      if (wr_addr >= OFF_PTR_BASE && wr_addr < OFF_PTR_BASE + 8'h30 && wr_addr[1:0] == 2'h0) begin
        wr_hit = 1'b1;
      end
      if (wr_addr >= OFF_PAL_BASE && wr_addr < OFF_PAL_BASE + 8'h40 && wr_addr[1:0] == 2'h0) begin
        wr_hit = 1'b1;
      end
    end
  end

  // Write response, held until it is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control words; unused bits are stored as zero, except bit 0 of the main control word, which is kept as written.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      plane_main_control <= MAIN_RESET;
      plane_scroll_delay <= '0;
      plane_priority_control <= '0;
      fetch_start_position <= '0;
      fetch_stop_position <= '0;
      window_start_coords <= '0;
      window_stop_coords <= '0;
      odd_plane_modulo <= '0;
      even_plane_modulo <= '0;
    end else if (do_write && wr_hit) begin
      case (wr_addr)
        OFF_MAIN: plane_main_control <= wr_data[15:0] & MAIN_MASK;
        OFF_SCROLL: plane_scroll_delay <= wr_data[15:0] & SCROLL_MASK;
        OFF_PRIO: plane_priority_control <= wr_data[15:0] & PRIO_MASK;
        OFF_FSTART: fetch_start_position <= wr_data[15:0] & FETCH_MASK;
        OFF_FSTOP: fetch_stop_position <= wr_data[15:0] & FETCH_MASK;
        OFF_WSTART: window_start_coords <= wr_data[15:0];
        OFF_WSTOP: window_stop_coords <= wr_data[15:0];
        OFF_ODD_MOD: odd_plane_modulo <= wr_data[15:0];
        OFF_EVEN_MOD: even_plane_modulo <= wr_data[15:0];
        default: begin
        end
      endcase
    end
  end

  // Plane pointers: high word at even slot, low word at odd slot.
  // Planes are eight bytes apart, so the plane number sits in address bits 5-3.
  assign wr_plane = wr_addr[5:3];
  assign rd_plane = araddr[5:3];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_PLANES; i++) begin
        plane_pointer_high[i] <= '0;
        plane_pointer_low[i] <= '0;
      end
    end else if (do_write && wr_hit && wr_addr >= OFF_PTR_BASE && wr_addr < OFF_PAL_BASE) begin
      if (wr_addr[2] == 1'b0) begin
        plane_pointer_high[wr_plane] <= wr_data[15:0];
      end else begin
        plane_pointer_low[wr_plane] <= wr_data[15:0];
      end
    end
  end

  // Palette entries 0 to 15; entry 0 is the background.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_PAL; i++) begin
        palette[i] <= '0;
      end
    end else if (do_write && wr_hit && wr_addr >= OFF_PAL_BASE) begin
      palette[wr_addr[5:2]] <= wr_data[11:0];
    end
  end

  // Read path: registers are write-only, only status and pointers read back.
  always_comb begin
    next_rdata = '0;
    rd_hit = 1'b1;
    if (araddr == OFF_STATUS) begin
      next_rdata = {19'h0, hold_on, held_color};
    end else if (araddr >= OFF_PTR_BASE && araddr < OFF_PTR_BASE + 8'h30
        && araddr[1:0] == 2'h0) begin
      if (araddr[2] == 1'b0) begin
        next_rdata = {16'h0, plane_pointer_high[rd_plane]};
      end else begin
        next_rdata = {16'h0, plane_pointer_low[rd_plane]};
      end
    end else if (araddr <= OFF_BACKGROUND && araddr[1:0] == 2'h0) begin
      next_rdata = '0;
    end else if (araddr >= OFF_PAL_BASE && araddr < OFF_PAL_BASE + 8'h40
        && araddr[1:0] == 2'h0) begin
      next_rdata = '0;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read answer; a new address is taken only once the last answer is gone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      arready <= 1'b0;
      rdata <= next_rdata;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // Hold-and-modify pixel path.
  assign hold_on = plane_main_control[BIT_HOLD] && !plane_main_control[BIT_DUAL]
    && !plane_main_control[BIT_HIGH_RESOLUTION_SELECT]
    && (plane_main_control[14:CNT_LSB] == CNT_FIVE
    || plane_main_control[14:CNT_LSB] == CNT_SIX);
  // The sixth plane counts only when six planes are enabled.
  assign mode_bits = {plane_bits[5] && (plane_main_control[14:CNT_LSB] == CNT_SIX),
    plane_bits[4]};
  assign low_bits = plane_bits[3:0];
  // The first pixel of a line has no left neighbour.
  assign left_color = line_start ? palette[0] : held_color;

  // Colour selection for one pixel.
  always_comb begin
    next_color = palette[low_bits];
    if (hold_on) begin
      case (mode_bits)
        MOD_PALETTE: next_color = palette[low_bits];
        MOD_BLUE: next_color = {left_color[11:4], low_bits};
        MOD_RED: next_color = {low_bits, left_color[7:0]};
        MOD_GREEN: next_color = {left_color[11:8], low_bits, left_color[3:0]};
        default: next_color = palette[low_bits];
      endcase
    end else begin
      case (plane_main_control[14:CNT_LSB])
        3'h0: next_color = palette[0];
        3'h1: next_color = palette[{3'h0, low_bits[0]}];
        3'h2: next_color = palette[{2'h0, low_bits[1:0]}];
        3'h3: next_color = palette[{1'h0, low_bits[2:0]}];
        default: next_color = palette[low_bits];
      endcase
    end
  end

  // Pixel register; the held colour is the left neighbour of the next pixel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_color <= '0;
      pixel_color <= '0;
      pixel_out_valid <= 1'b0;
    end else begin
      pixel_out_valid <= pixel_valid;
      if (pixel_valid) begin
        held_color <= next_color;
        pixel_color <= next_color;
      end
    end
  end

  // Registered decode of the control words onto video outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_modify_active <= 1'b0;
      external_sync_enable <= 1'b0;
      interlace_enable <= 1'b0;
      light_pen_enable <= 1'b0;
      genlock_audio_enable <= 1'b0;
      color_burst_enable <= 1'b0;
      dual_playfield_enable <= 1'b0;
      high_resolution_select <= 1'b0;
      active_plane_count <= '0;
      first_playfield_delay <= '0;
      second_playfield_delay <= '0;
      second_playfield_priority <= 1'b0;
      sprite_priority <= '0;
      fetch_start_h <= '0;
      fetch_stop_h <= '0;
      window_vertical_begin <= '0;
      window_horizontal_begin <= '0;
      window_vertical_end <= '0;
      window_horizontal_end <= '0;
    end else begin
      hold_modify_active <= hold_on;
      external_sync_enable <= plane_main_control[BIT_EXT_SYNC];
      interlace_enable <= plane_main_control[BIT_INTERLACE];
      light_pen_enable <= plane_main_control[BIT_LIGHT_PEN];
      genlock_audio_enable <= plane_main_control[BIT_GEN_AUDIO];
      color_burst_enable <= plane_main_control[BIT_BURST];
      dual_playfield_enable <= plane_main_control[BIT_DUAL];
      high_resolution_select <= plane_main_control[BIT_HIGH_RESOLUTION_SELECT];
      active_plane_count <= (plane_main_control[14:CNT_LSB] == 3'h7)
        ? 3'h0 : plane_main_control[14:CNT_LSB];
      first_playfield_delay <= plane_scroll_delay[3:0];
      second_playfield_delay <= plane_scroll_delay[7:4];
      second_playfield_priority <= plane_priority_control[PRI_BIT];
      sprite_priority <= plane_priority_control[5:0];
      fetch_start_h <= fetch_start_position[7:3];
      fetch_stop_h <= fetch_stop_position[7:3];
      window_vertical_begin <= window_start_coords[15:8];
      window_horizontal_begin <= window_start_coords[7:0];
      window_vertical_end <= window_stop_coords[15:8];
      window_horizontal_end <= window_stop_coords[7:0];
    end
  end
endmodule : bitplane_playfield_control

// ### bitplane_playfield_control_props.sv
// Concurrent checks on the ports of the playfield control block.
module playfield_props (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus answers.
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Pixel path and mode.
  input wire logic pixel_valid,
  input wire logic line_start,
  input wire logic [5:0] plane_bits,
  input wire logic pixel_out_valid,
  input wire logic [11:0] pixel_color,
  input wire logic hold_modify_active,
  input wire logic dual_playfield_enable,
  input wire logic high_resolution_select,
  input wire logic [2:0] active_plane_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A held pixel that is not the first of its line.
  wire logic mod = hold_modify_active && pixel_valid && !line_start;
  wire logic six = active_plane_count == 3'h6;
  property p_blue;
    mod && six && plane_bits[5:4] == 2'h1 |=>
      pixel_color == {$past(pixel_color[11:4]), $past(plane_bits[3:0])};
  endproperty
  property p_red;
    mod && six && plane_bits[5:4] == 2'h2 |=>
      pixel_color == {$past(plane_bits[3:0]), $past(pixel_color[7:0])};
  endproperty
  property p_green;
    mod && six && plane_bits[5:4] == 2'h3 |=> pixel_color ==
      {$past(pixel_color[11:8]), $past(plane_bits[3:0]), $past(pixel_color[3:0])};
  endproperty
  property p_five;
    mod && active_plane_count == 3'h5 && plane_bits[4] |=>
      pixel_color == {$past(pixel_color[11:4]), $past(plane_bits[3:0])};
  endproperty
  property p_one;
    mod && six && plane_bits[5:4] != 2'h0 |=> $countones({$stable(pixel_color[11:8]),
      $stable(pixel_color[7:4]), $stable(pixel_color[3:0])}) >= 2;
  endproperty
  property p_mode;
    hold_modify_active |-> !dual_playfield_enable && !high_resolution_select &&
      active_plane_count inside {3'h5, 3'h6};
  endproperty
  property p_count;
    active_plane_count != 3'h7;
  endproperty
  property p_pix;
    pixel_valid |=> pixel_out_valid;
  endproperty
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_blue: assert property (p_blue) else $error("blue replace wrong");
  a_red: assert property (p_red) else $error("red replace wrong");
  a_green: assert property (p_green) else $error("green replace wrong");
  a_five: assert property (p_five) else $error("five plane code wrong");
  a_one: assert property (p_one) else $error("more than one component changed");
  a_mode: assert property (p_mode) else $error("hold mode active wrongly");
  a_count: assert property (p_count) else $error("unused plane count shown");
  a_pix: assert property (p_pix) else $error("pixel output missing");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  c_red: cover property (mod && six && plane_bits[5:4] == 2'h2);
  c_five: cover property (mod && active_plane_count == 3'h5);
  c_err: cover property (bvalid && bresp == 2'h2);
endmodule : playfield_props

bind bitplane_playfield_control playfield_props u_props (.*);

// ### pixel_feeder.sv
// Plane fetch model that streams queued pixels with a periodic stall.
module pixel_feeder (
  // Clock.
  input wire logic aclk,
  // Pixel stream toward the block.
  output logic pixel_valid,
  output logic line_start,
  output logic [5:0] plane_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] q[$];
  int gap = 0;
  initial begin
    pixel_valid = 1'b0;
    line_start = 1'b0;
    plane_bits = 6'h2A;
  end
  // Idle cycles invert the plane lines so no stale value is shown.
  always @(posedge aclk) begin
    gap <= gap + 1;
    if (q.size() > 0 && gap % 5 != 4) begin
      {line_start, plane_bits} <= q.pop_front();
      pixel_valid <= 1'b1;
    end else begin
      pixel_valid <= 1'b0;
      line_start <= 1'b0;
      plane_bits <= ~plane_bits;
    end
  end
endmodule : pixel_feeder

// ### playfield_pkg.sv
// Package with register map, field positions and hold-and-modify constants.
package playfield_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_SCROLL = 8'h04;
  localparam logic [7:0] OFF_PRIO = 8'h08;
  localparam logic [7:0] OFF_FSTART = 8'h0C;
  localparam logic [7:0] OFF_FSTOP = 8'h10;
  localparam logic [7:0] OFF_WSTART = 8'h14;
  localparam logic [7:0] OFF_WSTOP = 8'h18;
  localparam logic [7:0] OFF_ODD_MOD = 8'h1C;
  localparam logic [7:0] OFF_EVEN_MOD = 8'h20;
  localparam logic [7:0] OFF_BACKGROUND = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_PTR_BASE = 8'h40;
  localparam logic [7:0] OFF_PAL_BASE = 8'h80;
  localparam int NUM_PLANES = 6;
  localparam int NUM_PAL = 16;
  localparam int BIT_EXT_SYNC = 1;
  localparam int BIT_INTERLACE = 2;
  localparam int BIT_LIGHT_PEN = 3;
  localparam int BIT_GEN_AUDIO = 8;
  localparam int BIT_BURST = 9;
  localparam int BIT_DUAL = 10;
  localparam int BIT_HOLD = 11;
  localparam int BIT_HIGH_RESOLUTION_SELECT = 15;
  localparam int CNT_LSB = 12;
  localparam logic [2:0] CNT_FIVE = 3'h5;
  localparam logic [2:0] CNT_SIX = 3'h6;
  localparam logic [15:0] MAIN_RESET = 16'h0000;
  localparam logic [15:0] MAIN_MASK = 16'hFF0F;
  localparam logic [15:0] SCROLL_MASK = 16'h00FF;
  localparam logic [15:0] PRIO_MASK = 16'h007F;
  localparam logic [15:0] FETCH_MASK = 16'h00F8;
  localparam int PRI_BIT = 6;
  localparam logic [1:0] MOD_PALETTE = 2'h0;
  localparam logic [1:0] MOD_BLUE = 2'h1;
  localparam logic [1:0] MOD_RED = 2'h2;
  localparam logic [1:0] MOD_GREEN = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : playfield_pkg

// ### tb_bitplane_playfield_control.sv
// Self-checking bench for the playfield control block.
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_bitplane_playfield_control;
  timeunit 1ns;
  timeprecision 1ps;
  import playfield_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, seed = 32'h7853AABE;
  logic [3:0] wstrb = 0, first_playfield_delay, second_playfield_delay;
  logic awready, wready, bvalid, arready, rvalid, pixel_out_valid, hold_modify_active;
  logic external_sync_enable, interlace_enable, light_pen_enable, genlock_audio_enable;
  logic color_burst_enable, dual_playfield_enable, high_resolution_select;
  logic second_playfield_priority, pixel_valid, line_start;
  logic [1:0] bresp, rresp;
  logic [2:0] active_plane_count;
  logic [4:0] fetch_start_h, fetch_stop_h;
  logic [5:0] sprite_priority, plane_bits;
  logic [7:0] window_vertical_begin, window_horizontal_begin;
  logic [7:0] window_vertical_end, window_horizontal_end;
  logic [11:0] pixel_color, held, exp_c, pal[16];
  logic [11:0] exp_q[$];
  logic [15:0] odd_plane_modulo, even_plane_modulo, ptr[12];
  int miscompares = 0, n_tests = 0;
  bitplane_playfield_control u_dut (.*);
  pixel_feeder u_feed (.aclk, .pixel_valid, .line_start, .plane_bits);
  always #4 aclk = ~aclk;
  task automatic summarize();
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int x;
    x = $random(seed);
    @(posedge aclk);
    {awvalid, wvalid} <= 2'h3;
    bready <= x[0];
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
    end while (bvalid !== 1'b1 || bready !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int x;
    x = $random(seed);
    @(posedge aclk);
    arvalid <= 1'b1;
    rready <= x[0];
    araddr <= a;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
    end while (rvalid !== 1'b1 || rready !== 1'b1);
    rready <= 1'b0;
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask : rd
  task automatic chk_main(input logic [15:0] v);
    logic [2:0] n;
    logic h;
    n = (v[14:12] == 3'h7) ? 3'h0 : v[14:12];
    h = v[11] && !v[10] && !v[15] && (n == CNT_FIVE || n == CNT_SIX);
    repeat (2) @(posedge aclk);
    `CHK(external_sync_enable, v[1])
    `CHK(interlace_enable, v[2])
    `CHK(light_pen_enable, v[3])
    `CHK(genlock_audio_enable, v[8])
    `CHK(color_burst_enable, v[9])
    `CHK(dual_playfield_enable, v[10])
    `CHK(active_plane_count, n)
    `CHK(high_resolution_select, v[15])
    `CHK(hold_modify_active, h)
  endtask : chk_main
  // The model keeps the colour of the last pixel as the left neighbour.
  task automatic pix(input int planes, input logic ls, input logic [5:0] b);
    logic [1:0] c;
    c = (planes == 5) ? {1'b0, b[4]} : b[5:4];
    if (ls) held = pal[0];
    if (planes == 3) held = pal[{1'b0, b[2:0]}];
    else case (c)
      2'h0: held = pal[b[3:0]];
      2'h1: held[3:0] = b[3:0];
      2'h2: held[11:8] = b[3:0];
      default: held[7:4] = b[3:0];
    endcase
    u_feed.q.push_back({ls, b});
    exp_q.push_back(held);
  endtask : pix
  always @(posedge aclk) begin
    if (pixel_out_valid === 1'b1) begin
      exp_c = exp_q.pop_front();
      `CHK(pixel_color, exp_c)
    end
  end
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
  initial begin
    logic [31:0] r, u;
    logic [15:0] m[4];
    m = '{16'h6A00, 16'h5A00, 16'h7A00, 16'h3200};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_MAIN, 0, RESP_OKAY);
    rd(8'hFC, 0, RESP_SLVERR);
    wr(8'hFC, 1, 4'hF, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed) & MAIN_MASK;
      wr(OFF_MAIN, r, 4'hF, RESP_OKAY);
      chk_main(r[15:0]);
    end
    wr(OFF_MAIN, 32'hFFFF, 4'h1, RESP_SLVERR);
    chk_main(r[15:0]);
    r = $random(seed);
    u = ~r;
    wr(OFF_SCROLL, r, 4'hF, RESP_OKAY);
    wr(OFF_PRIO, r, 4'hF, RESP_OKAY);
    wr(OFF_FSTART, r, 4'hF, RESP_OKAY);
    wr(OFF_FSTOP, u, 4'hF, RESP_OKAY);
    wr(OFF_WSTART, r, 4'hF, RESP_OKAY);
    wr(OFF_WSTOP, u, 4'hF, RESP_OKAY);
    wr(OFF_ODD_MOD, r, 4'hF, RESP_OKAY);
    wr(OFF_EVEN_MOD, u, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(first_playfield_delay, r[3:0])
    `CHK(second_playfield_delay, r[7:4])
    `CHK(second_playfield_priority, r[6])
    `CHK(sprite_priority, r[5:0])
    `CHK(fetch_start_h, r[7:3])
    `CHK(fetch_stop_h, u[7:3])
    `CHK({window_vertical_begin, window_horizontal_begin}, r[15:0])
    `CHK({window_vertical_end, window_horizontal_end}, u[15:0])
    `CHK(odd_plane_modulo, r[15:0])
    `CHK(even_plane_modulo, u[15:0])
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      ptr[i] = r[15:0];
      wr(OFF_PTR_BASE + 8'(4 * i), {16'h0, ptr[i]}, 4'hF, RESP_OKAY);
    end
    for (int i = 0; i < 12; i++) begin
      rd(OFF_PTR_BASE + 8'(4 * i), {16'h0, ptr[i]}, RESP_OKAY);
    end
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      pal[i] = r[11:0];
      wr(OFF_PAL_BASE + 8'(4 * i), {20'h0, pal[i]}, 4'hF, RESP_OKAY);
    end
    for (int k = 0; k < 4; k++) begin
      wr(OFF_MAIN, {16'h0, m[k]}, 4'hF, RESP_OKAY);
      chk_main(m[k]);
      for (int i = 0; i < 80 && k != 2; i++) begin
        r = $random(seed);
        pix((k == 3) ? 3 : 6 - k, i % 40 == 0, r[5:0]);
      end
      while (exp_q.size() != 0) @(posedge aclk);
      repeat (2) @(posedge aclk);
    end
    rd(OFF_STATUS, {20'h0, held}, RESP_OKAY);
    summarize();
  end
endmodule : tb_bitplane_playfield_control
